// ### hdl/input_sync.sv
/*
  two-flop synchroniser with rising-edge detect for one digital input.
  assumes the input is asynchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module input_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);

  logic meta;
  logic sync;
  logic prev;

  // ----------------------------------------------------------------
  // synchroniser; meta is read by sync only
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_level = sync;
  assign o_rise  = sync & ~prev;

endmodule

`default_nettype wire

// ### hdl/motion_program_pkg.sv
/*
  shared constants and types for the motion program sequencer.
  assumes one 20 MHz control clock and a synchronous active-low reset.
*/
package motion_program_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int STEP_BITS   = 4;
  localparam int NUM_STEPS   = 16;
  localparam int NUM_DIN     = 8;
  localparam int DIN_BITS    = 3;

  // ----------------------------------------------------------------
  // reaction modes of a step to the branch inputs
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    react_final,
    react_ignore,
    react_hold,
    react_immediate,
    react_after
  } reaction_type;

  // ----------------------------------------------------------------
  // register offsets (byte offsets; word index = byte offset >> 2)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_ENTRY   = 8'h04;
  localparam logic [7:0] ADDR_INMAP   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_STEP0   = 8'h40;

  // ----------------------------------------------------------------
  // step word fields
  // ----------------------------------------------------------------
  localparam int STEP_NEXT_A_LSB = 0;
  localparam int STEP_NEXT_B_LSB = 4;
  localparam int STEP_MODE_LSB   = 8;
  localparam int STEP_NOSTOP_BIT = 11;

  // ----------------------------------------------------------------
  // input map fields and reset values
  // ----------------------------------------------------------------
  localparam int MAP_HOME_LSB  = 0;
  localparam int MAP_START_LSB = 3;
  localparam int MAP_A_LSB     = 6;
  localparam int MAP_B_LSB     = 9;
  localparam int MAP_STOP_LSB  = 12;
  localparam int ENTRY_HOME_LSB  = 0;
  localparam int ENTRY_START_LSB = 8;
  localparam logic [DIN_BITS-1:0] RST_MAP_HOME  = 3'h0;
  localparam logic [DIN_BITS-1:0] RST_MAP_START = 3'h1;
  localparam logic [DIN_BITS-1:0] RST_MAP_A     = 3'h2;
  localparam logic [DIN_BITS-1:0] RST_MAP_B     = 3'h3;
  localparam logic [DIN_BITS-1:0] RST_MAP_STOP  = 3'h4;
  localparam logic [STEP_BITS-1:0] RST_ENTRY_HOME  = 4'h1;
  localparam logic [STEP_BITS-1:0] RST_ENTRY_START = 4'h2;
  localparam logic [11:0] RST_STEP = 12'h000;

endpackage

// ### hdl/motion_program_sequencer.sv
/*
  motion program sequencer: chains stored steps, branches on two inputs,
  honours stop with per-step deferral.
  assumes a trajectory unit that takes o_target/o_go and answers i_reached.
*/
`timescale 1ns/10ps
`default_nettype none

module motion_program_sequencer
#(
  parameter int STEPS = motion_program_pkg::NUM_STEPS
)
(
  input  wire logic                                      i_clk,
  input  wire logic                                      i_rst_n,
  input  wire logic [motion_program_pkg::NUM_DIN-1:0]    i_din,
  input  wire logic                                      i_reached,
  input  wire logic [7:0]                                i_addr,
  input  wire logic [31:0]                               i_wdata,
  input  wire logic                                      i_wr,
  input  wire logic                                      i_rd,
  output logic      [31:0]                               o_rdata,
  output logic      [motion_program_pkg::STEP_BITS-1:0]  o_target,
  output logic                                           o_go,
  output logic                                           o_running
);

  localparam int SB = motion_program_pkg::STEP_BITS;
  localparam int DB = motion_program_pkg::DIN_BITS;

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic          enable;
  logic [SB-1:0] entry_home;
  logic [SB-1:0] entry_start;
  logic [DB-1:0] map_home;
  logic [DB-1:0] map_start;
  logic [DB-1:0] map_a;
  logic [DB-1:0] map_b;
  logic [DB-1:0] map_stop;
  logic [11:0]   step_mem [STEPS];

  // ----------------------------------------------------------------
  // input synchronisers, one per pin
  // ----------------------------------------------------------------
  logic [motion_program_pkg::NUM_DIN-1:0] din_level;
  logic [motion_program_pkg::NUM_DIN-1:0] din_rise;

  genvar g;
  generate
    for (g = 0; g < motion_program_pkg::NUM_DIN; g++)
    begin : gen_sync
      input_sync u_sync
      (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_din[g]),
        .o_level (din_level[g]),
        .o_rise  (din_rise[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // mapped input functions
  // ----------------------------------------------------------------
  wire branch_a_level = din_level[map_a];
  wire branch_b_level = din_level[map_b];
  wire branch_a_rise  = din_rise[map_a];
  wire branch_b_rise  = din_rise[map_b];
  wire stop_level     = din_level[map_stop];
  wire home_rise      = din_rise[map_home];
  wire start_rise     = din_rise[map_start];

  // ----------------------------------------------------------------
  // current step decode
  // ----------------------------------------------------------------
  logic [SB-1:0] cur;
  wire  [11:0]   cur_word = step_mem[cur];
  wire  [SB-1:0] next_a_idx = cur_word[motion_program_pkg::STEP_NEXT_A_LSB +: SB];
  wire  [SB-1:0] next_b_idx = cur_word[motion_program_pkg::STEP_NEXT_B_LSB +: SB];
  wire  [2:0]    mode_bits  = cur_word[motion_program_pkg::STEP_MODE_LSB +: 3];
  wire           no_stop    = cur_word[motion_program_pkg::STEP_NOSTOP_BIT];
  motion_program_pkg::reaction_type mode;
  assign mode = motion_program_pkg::reaction_type'(mode_bits);

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_move, st_wait} seq_state_type;

  seq_state_type state;
  seq_state_type next_state;
  logic          stop_saved;
  logic          edge_seen;
  logic          edge_is_b;
  logic [SB-1:0] next_cur;
  logic          next_go;
  logic          next_stop_saved;

  // entries may start only while idle and enabled
  wire entry_req = enable & (home_rise | start_rise);
  wire [SB-1:0] entry_idx = home_rise ? entry_home : entry_start;

  // stop sampled as a level so a held stop is never missed
  wire stop_now = stop_level & ~no_stop;

  // ----------------------------------------------------------------
  // sequencing decisions
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_cur        = cur;
    next_go         = 1'b0;
    next_stop_saved = stop_saved | (stop_level & no_stop);
    case (state)
      st_idle:
      begin
        next_stop_saved = 1'b0;
        if (entry_req)
        begin
          next_cur   = entry_idx;
          next_go    = 1'b1;
          next_state = st_move;
        end
      end
      st_move:
      begin
        if (!enable || stop_now)
          next_state = st_idle;
        else if (mode == motion_program_pkg::react_immediate && (branch_a_level || branch_b_level)
                 && stop_saved && !no_stop)
          next_state = st_idle;                             // abandoning a step still ends it
        else if (mode == motion_program_pkg::react_immediate && (branch_a_level || branch_b_level))
        begin
          next_cur = branch_a_level ? next_a_idx : next_b_idx;
          next_go  = 1'b1;
        end
        else if (i_reached)
        begin
          if (mode == motion_program_pkg::react_final)
            next_state = st_idle;
          else if (stop_saved && !no_stop)
            next_state = st_idle;
          else if (mode == motion_program_pkg::react_ignore)
          begin
            next_cur = next_a_idx;
            next_go  = 1'b1;
          end
          else if (mode == motion_program_pkg::react_after)
          begin
            if (edge_seen)
            begin
              next_cur = edge_is_b ? next_b_idx : next_a_idx;
              next_go  = 1'b1;
            end
            else
              next_state = st_wait;
          end
          else
            next_state = st_wait;
        end
      end
      st_wait:
      begin
        if (!enable || stop_now)
          next_state = st_idle;
        else if (branch_a_level || branch_b_level)
        begin
          next_cur   = branch_a_level ? next_a_idx : next_b_idx;
          next_go    = 1'b1;
          next_state = st_move;
        end
      end
      default:
        next_state = st_idle;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state      <= st_idle;
      cur        <= '0;
      o_go       <= 1'b0;
      stop_saved <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cur        <= next_cur;
      o_go       <= next_go;
      stop_saved <= next_stop_saved;
    end
  end

  // ----------------------------------------------------------------
  // edge recorder for evaluate-after-target steps
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || next_go)
    begin
      edge_seen <= 1'b0;
      edge_is_b <= 1'b0;
    end
    else if (state == st_move && (branch_a_rise || branch_b_rise))
    begin
      edge_seen <= 1'b1;
      edge_is_b <= ~branch_a_rise;
    end
  end

  assign o_target  = cur;
  assign o_running = (state != st_idle);

  // ----------------------------------------------------------------
  // register port: writes
  // ----------------------------------------------------------------
  wire wr_ctrl  = i_wr && i_addr == motion_program_pkg::ADDR_CONTROL;
  wire wr_entry = i_wr && i_addr == motion_program_pkg::ADDR_ENTRY;
  wire wr_map   = i_wr && i_addr == motion_program_pkg::ADDR_INMAP;
  wire is_step  = i_addr >= motion_program_pkg::ADDR_STEP0 &&
                  i_addr <  motion_program_pkg::ADDR_STEP0 + 8'(4 * STEPS) && i_addr[1:0] == 2'b00;
  wire [SB-1:0] step_sel = SB'((i_addr - motion_program_pkg::ADDR_STEP0) >> 2);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      enable      <= 1'b0;
      entry_home  <= motion_program_pkg::RST_ENTRY_HOME;
      entry_start <= motion_program_pkg::RST_ENTRY_START;
      map_home    <= motion_program_pkg::RST_MAP_HOME;
      map_start   <= motion_program_pkg::RST_MAP_START;
      map_a       <= motion_program_pkg::RST_MAP_A;
      map_b       <= motion_program_pkg::RST_MAP_B;
      map_stop    <= motion_program_pkg::RST_MAP_STOP;
    end
    else
    begin
      if (wr_ctrl)
        enable <= i_wdata[0];
      if (wr_entry)
      begin
        entry_home  <= i_wdata[motion_program_pkg::ENTRY_HOME_LSB +: SB];
        entry_start <= i_wdata[motion_program_pkg::ENTRY_START_LSB +: SB];
      end
      if (wr_map)
      begin
        map_home  <= i_wdata[motion_program_pkg::MAP_HOME_LSB +: DB];
        map_start <= i_wdata[motion_program_pkg::MAP_START_LSB +: DB];
        map_a     <= i_wdata[motion_program_pkg::MAP_A_LSB +: DB];
        map_b     <= i_wdata[motion_program_pkg::MAP_B_LSB +: DB];
        map_stop  <= i_wdata[motion_program_pkg::MAP_STOP_LSB +: DB];
      end
    end
  end

  // step table has no reset; software loads it before enabling
  always_ff @(posedge i_clk)
  begin
    if (i_wr && is_step)
      step_mem[step_sel] <= i_wdata[11:0];
  end

  // ----------------------------------------------------------------
  // register port: reads, data valid one cycle later
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (i_addr == motion_program_pkg::ADDR_CONTROL)
      rd_mux = {31'h0, enable};
    else if (i_addr == motion_program_pkg::ADDR_ENTRY)
      rd_mux = {20'h0, entry_start, 4'h0, entry_home};
    else if (i_addr == motion_program_pkg::ADDR_INMAP)
      rd_mux = {17'h0, map_stop, map_b, map_a, map_start, map_home};
    else if (i_addr == motion_program_pkg::ADDR_STATUS)
      rd_mux = {22'h0, edge_is_b, edge_seen, stop_saved, o_running, 2'h0, cur};
    else if (is_step)
      rd_mux = {20'h0, step_mem[step_sel]};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst_n && i_rd)
      o_rdata <= rd_mux;                                    // stands one cycle only
    else
      o_rdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_final_ends;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && mode == motion_program_pkg::react_final && i_reached && enable && !stop_now) |=> !o_running;
  endproperty
  a_final_ends: assert property (p_final_ends) else $error("final step did not end run");
  property p_stop_ends;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state != st_idle && stop_level && !no_stop) |=> !o_running;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end run");
  property p_nostop_runs;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && stop_level && no_stop && enable && !i_reached) |=> o_running && stop_saved;
  endproperty
  a_nostop_runs: assert property (p_nostop_runs) else $error("no-stop step halted");
  property p_ignore_next;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && mode == motion_program_pkg::react_ignore && i_reached && enable
     && !stop_now && !stop_saved) |=> (o_go && o_target == $past(next_a_idx));
  endproperty
  a_ignore_next: assert property (p_ignore_next) else $error("ignore step wrong successor");
  property p_immediate;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && mode == motion_program_pkg::react_immediate && branch_a_level && enable
     && !stop_now && !(stop_saved && !no_stop)) |=> (o_go && o_target == $past(next_a_idx));
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate branch not taken");
  property p_hold_moving;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && mode == motion_program_pkg::react_hold && !i_reached) |=> !o_go;
  endproperty
  a_hold_moving: assert property (p_hold_moving) else $error("hold step branched early");
  property p_after_edge;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_move && !next_go && branch_b_rise && !branch_a_rise) |=> (edge_seen && edge_is_b);
  endproperty
  a_after_edge: assert property (p_after_edge) else $error("edge not recorded");
  property p_entry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == st_idle && !enable) |=> !o_running;
  endproperty
  a_entry: assert property (p_entry) else $error("run started while disabled");
  property p_go_running;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_go |-> o_running;
  endproperty
  a_go_running: assert property (p_go_running) else $error("go pulse outside run");

endmodule

`default_nettype wire

// ### sim/motion_controller_model.sv
/*
  stand-in for the superordinate controller and the trajectory unit.
  assumes the bench calls drive() and sets reach_delay hierarchically.
*/
`timescale 1ns/10ps
`default_nettype none

module motion_controller_model
(
  input  wire logic       i_clk,
  input  wire logic       i_go,
  output logic      [7:0] o_din,
  output logic            o_reached
);
  int cnt         = 0;
  int reach_delay = 4;

  // ----------------------------------------------------------------
  // trajectory: arrival reach_delay cycles after each start
  // ----------------------------------------------------------------
  // arrival drops with go so an old arrival never closes the new step
  assign o_reached = (cnt >= reach_delay) & ~i_go;

  always @(posedge i_clk)
  begin
    if (i_go)
      cnt <= 0;
    else if (cnt < 1000)
      cnt <= cnt + 1;
  end

  // ----------------------------------------------------------------
  // digital inputs
  // ----------------------------------------------------------------
  initial o_din = 8'h00;

  // raise the masked inputs; n of 0 leaves them high, else held n cycles but at least 4
  task automatic drive(input logic [7:0] m, input int n);
    @(posedge i_clk);
    o_din <= o_din | m;
    if (n > 0)
    begin
      repeat ((n < 4) ? 4 : n) @(posedge i_clk);
      o_din <= o_din & ~m;
    end
  endtask

  // drop inputs left high by drive(m, 0)
  task automatic release_pins(input logic [7:0] m);
    @(posedge i_clk);
    o_din <= o_din & ~m;
  endtask
endmodule

`default_nettype wire

// ### sim/tb.sv
/*
  self-checking bench for the motion program sequencer.
  assumes the controller model in motion_controller_model.sv.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        wr_s    = 1'b0;
  logic        rd_s    = 1'b0;
  logic [7:0]  din;
  logic        reached;
  logic [31:0] rdata;
  logic [3:0]  target;
  logic        go;
  logic        running;
  logic [31:0] v;
  int          err_total  = 0;
  int          num_checks = 0;
  int          go_count   = 0;
  // step words {ignore-stop, mode, succ b, succ a} for steps 0..12
  logic [11:0] tbl [13] = '{12'h000, 12'h363, 12'h298, 12'h104, 12'h905, 12'h107, 12'h000,
                            12'h000, 12'h496, 12'h000, 12'h3cb, 12'h000, 12'h109};

  always #25 clk = ~clk;

  // count start pulses; sampled before the edge's own updates land
  always @(posedge clk)
  begin
    if (go === 1'b1)
      go_count <= go_count + 1;
  end

  motion_program_sequencer #(.STEPS(motion_program_pkg::NUM_STEPS)) u_dut
  (
    .i_clk(clk), .i_rst_n(rst_n), .i_din(din), .i_reached(reached), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_target(target),
    .o_go(go), .o_running(running)
  );

  motion_controller_model u_ctl (.i_clk(clk), .i_go(go), .o_din(din), .o_reached(reached));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  // bounded wait for a step and run state, or a fixed span when nothing may move
  task automatic see(input logic [3:0] t, input logic run, input int lim, input bit fixed);
    int k;
    #1; // let updates launched at the calling edge settle first
    for (k = 0; k < lim; k++)
    begin
      if (!fixed && target === t && running === run)
        break;
      @(posedge clk);
      #1;
    end
    chk("target", {28'h0, target}, {28'h0, t});
    chk("running", {31'h0, running}, {31'h0, run});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: whole sequence needs well under 2000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(motion_program_pkg::ADDR_INMAP, v);
    chk("input map", v, 32'h0000_4688);
    rd(motion_program_pkg::ADDR_ENTRY, v);
    chk("entry", v, 32'h0000_0201);
    rd(8'h3c, v);
    chk("unmapped", v, 32'h0000_0000);
    for (int i = 0; i < 13; i++)
      wr(motion_program_pkg::ADDR_STEP0 + 8'(4 * i), {20'h0, tbl[i]});
    rd(8'h60, v);
    chk("step 8 word", v, 32'h0000_0496);
    // entry refused while the program setting is off
    u_ctl.drive(8'h01, 4);
    see(4'h0, 1'b0, 12, 1'b1);
    wr(motion_program_pkg::ADDR_CONTROL, 32'h1);
    // immediate step re-targets on branch b, final step ends the run
    u_ctl.reach_delay = 40;
    u_ctl.drive(8'h01, 4);
    see(4'h1, 1'b1, 20, 1'b0);
    u_ctl.drive(8'h08, 5);
    see(4'h6, 1'b1, 20, 1'b0);
    see(4'h6, 1'b0, 80, 1'b0);
    chk("go pulses", go_count, 32'h0000_0002);
    // hold step: branch a held early only counts after arrival
    u_ctl.drive(8'h02, 4);
    see(4'h2, 1'b1, 20, 1'b0);
    u_ctl.drive(8'h04, 0);
    see(4'h2, 1'b1, 12, 1'b1);
    see(4'h8, 1'b1, 60, 1'b0);
    u_ctl.release_pins(8'h04);
    // after-target step: edge a then edge b, latest edge wins at arrival
    u_ctl.drive(8'h04, 4);
    u_ctl.drive(8'h08, 4);
    rd(motion_program_pkg::ADDR_STATUS, v);
    chk("status after edges", v, 32'h0000_0348);
    see(4'h9, 1'b1, 60, 1'b0);
    see(4'h9, 1'b0, 60, 1'b0);
    // stop on an ignore-stop step is saved and ends the following step
    wr(motion_program_pkg::ADDR_ENTRY, 32'h0000_0203);
    u_ctl.drive(8'h01, 4);
    see(4'h3, 1'b1, 20, 1'b0);
    see(4'h4, 1'b1, 60, 1'b0);
    u_ctl.drive(8'h10, 4);
    see(4'h4, 1'b1, 8, 1'b1);
    rd(motion_program_pkg::ADDR_STATUS, v);
    chk("stop saved", v & 32'h80, 32'h0000_0080);
    see(4'h5, 1'b1, 60, 1'b0);
    see(4'h5, 1'b1, 10, 1'b1);
    see(4'h5, 1'b0, 60, 1'b0);
    // both branches at once: a wins; plain stop ends the run before arrival
    wr(motion_program_pkg::ADDR_ENTRY, 32'h0000_020a);
    u_ctl.reach_delay = 200;
    u_ctl.drive(8'h01, 4);
    see(4'ha, 1'b1, 20, 1'b0);
    u_ctl.drive(8'h0c, 5);
    see(4'hb, 1'b1, 20, 1'b0);
    u_ctl.drive(8'h10, 4);
    see(4'hb, 1'b0, 20, 1'b0);
    // ignore step jumps back to an earlier final step
    wr(motion_program_pkg::ADDR_ENTRY, 32'h0000_020c);
    u_ctl.reach_delay = 10;
    u_ctl.drive(8'h01, 4);
    see(4'hc, 1'b1, 20, 1'b0);
    see(4'h9, 1'b1, 40, 1'b0);
    see(4'h9, 1'b0, 40, 1'b0);
    chk("go pulses", go_count, 32'h0000_000c);
    test_done();
  end
endmodule

`default_nettype wire
